/* File: pkg/card_port_params.svh */
// Constants of the card host port control logic: pin slots, timing, reset values.
// Assumes a 200 MHz core clock; included by the design file and the bench.
`ifndef CARD_PORT_PARAMS_SVH
`define CARD_PORT_PARAMS_SVH
// ****************************************************
// Pin slots in the synchronised pin vector
// ****************************************************
`define PIN_OE      0
`define PIN_WE      1
`define PIN_IORD    2
`define PIN_IOWR    3
`define PIN_REG     4
`define PIN_RESET   5
`define PIN_DMACK   6
`define PIN_CE1     7
`define PIN_CE2     8
`define PIN_COUNT   9
// Idle level of every pin while the synchroniser fills (reset pin idles low)
`define PIN_IDLE    9'h1DF
// ****************************************************
// Timing
// ****************************************************
`define CLK_MHZ         200
`define INIT_TIME_NS    1000
`define INIT_CYCLES     ((`INIT_TIME_NS * `CLK_MHZ + 999) / 1000)
`define STRAP_CYCLES    3
`endif

/* File: pkg/card_port_pkg.sv */
// Types of the card host port control logic.
// Assumes nothing beyond the params header.
package card_port_pkg;
	// Interface personality of the card
	typedef enum logic [1:0] {mode_mem, mode_io, mode_ide} mode_type;
	// Card life cycle after a reset
	typedef enum logic [1:0] {st_strap, st_init, st_ready, st_hold} state_type;
endpackage

/* File: rtl/card_host_port.sv */
// Control pins of the card host port in memory, I/O and IDE personality.
// Assumes pins arrive asynchronously; core signals share clk; 200 MHz clock.
`timescale 1ns/1ps
`include "card_port_params.svh"

module card_host_port #(
	parameter int INIT_CYCLES = `INIT_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic oe_n,
	input  wire logic we_n,
	input  wire logic iord_n,
	input  wire logic iowr_n,
	input  wire logic reg_n,
	input  wire logic reset_pin,
	input  wire logic dmack_n,
	input  wire logic ce1_n,
	input  wire logic ce2_n,
	input  wire logic io_mode_sel,
	input  wire logic irq_req,
	input  wire logic dma_req,
	input  wire logic word_xfer,
	output logic      attr_rd,
	output logic      attr_wr,
	output logic      tf_rd,
	output logic      tf_wr,
	output logic      dma_ack,
	output logic      busy,
	output logic      regs_clear,
	output logic      ide_mode,
	output logic      rdy_irq_o,
	output logic      wp_io16_o,
	output logic      wait_o,
	output logic      wait_oe,
	output logic      dmarq
);

	// ****************************************************
	// Pin synchroniser
	// ****************************************************
	logic [`PIN_COUNT-1:0] pin_raw;
	logic [`PIN_COUNT-1:0] pin_s1_r;
	logic [`PIN_COUNT-1:0] pin_s2_r;
	logic [`PIN_COUNT-1:0] pin_s3_r;

	assign pin_raw = {ce2_n, ce1_n, dmack_n, reset_pin, reg_n, iowr_n, iord_n, we_n, oe_n};

	// Two stages per pin, third stage only for edge detection
	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g++)
		begin : g_sync
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					pin_s1_r[g] <= 1'(`PIN_IDLE >> g);
					pin_s2_r[g] <= 1'(`PIN_IDLE >> g);
					pin_s3_r[g] <= 1'(`PIN_IDLE >> g);
				end
				else
				begin
					pin_s1_r[g] <= pin_raw[g];
					pin_s2_r[g] <= pin_s1_r[g];
					pin_s3_r[g] <= pin_s2_r[g];
				end
			end
		end
	endgenerate

	// Falling edges of the active low strobes, and card enable levels
	logic oe_fall;
	logic we_fall;
	logic iord_fall;
	logic iowr_fall;
	logic ce_any;
	logic ce_word;

	assign oe_fall   = pin_s3_r[`PIN_OE] & ~pin_s2_r[`PIN_OE];
	assign we_fall   = pin_s3_r[`PIN_WE] & ~pin_s2_r[`PIN_WE];
	assign iord_fall = pin_s3_r[`PIN_IORD] & ~pin_s2_r[`PIN_IORD];
	assign iowr_fall = pin_s3_r[`PIN_IOWR] & ~pin_s2_r[`PIN_IOWR];
	assign ce_any    = ~pin_s2_r[`PIN_CE1] | ~pin_s2_r[`PIN_CE2];
	assign ce_word   = ~pin_s2_r[`PIN_CE1] & ~pin_s2_r[`PIN_CE2];

	// ****************************************************
	// Mode strap and initialization sequencer
	// ****************************************************
	card_port_pkg::state_type state_r;
	card_port_pkg::state_type state_nxt;
	logic                     strap_ide_r;
	logic                     strap_ide_nxt;
	logic [15:0]              cnt_r;
	logic [15:0]              cnt_nxt;
	logic                     pin_reset;
	logic                     ready;
	card_port_pkg::mode_type  mode;

	// Reset pin polarity follows the personality
	assign pin_reset = strap_ide_r ? ~pin_s2_r[`PIN_RESET] : pin_s2_r[`PIN_RESET];
	assign ready     = (state_r == card_port_pkg::st_ready);
	assign mode      = strap_ide_r ? card_port_pkg::mode_ide :
		(io_mode_sel ? card_port_pkg::mode_io : card_port_pkg::mode_mem);

	// Next state, strap and counter
	always_comb
	begin
		state_nxt     = state_r;
		strap_ide_nxt = strap_ide_r;
		cnt_nxt       = cnt_r;
		case (state_r)
			card_port_pkg::st_strap:
			begin
				// Wait for the synchroniser to settle, then latch OE level
				if (cnt_r == 16'(`STRAP_CYCLES - 1))
				begin
					strap_ide_nxt = ~pin_s2_r[`PIN_OE];
					cnt_nxt       = 16'h0000;
					state_nxt     = card_port_pkg::st_init;
				end
				else
					cnt_nxt = cnt_r + 16'h0001;
			end
			card_port_pkg::st_init:
			begin
				if (pin_reset)
				begin
					cnt_nxt   = 16'h0000;
					state_nxt = card_port_pkg::st_hold;
				end
				else if (cnt_r == 16'(INIT_CYCLES - 1))
				begin
					cnt_nxt   = 16'h0000;
					state_nxt = card_port_pkg::st_ready;
				end
				else
					cnt_nxt = cnt_r + 16'h0001;
			end
			card_port_pkg::st_ready:
			begin
				if (pin_reset)
					state_nxt = card_port_pkg::st_hold;
			end
			default:
			begin
				// Pin reset held: restart strap on release
				cnt_nxt = 16'h0000;
				if (!pin_reset)
					state_nxt = card_port_pkg::st_strap;
			end
		endcase
	end

	// Register sequencer state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r     <= card_port_pkg::st_strap;
			strap_ide_r <= 1'b0;
			cnt_r       <= 16'h0000;
		end
		else
		begin
			state_r     <= state_nxt;
			strap_ide_r <= strap_ide_nxt;
			cnt_r       <= cnt_nxt;
		end
	end

	// ****************************************************
	// Strobe decode and pin outputs
	// ****************************************************
	logic attr_rd_r;
	logic attr_rd_nxt;
	logic attr_wr_r;
	logic attr_wr_nxt;
	logic tf_rd_r;
	logic tf_rd_nxt;
	logic tf_wr_r;
	logic tf_wr_nxt;
	logic dma_ack_r;
	logic dma_ack_nxt;
	logic dmarq_r;
	logic dmarq_nxt;
	logic pin37_r;
	logic pin37_nxt;
	logic pin24_r;
	logic pin24_nxt;
	logic wait_o_r;
	logic wait_o_nxt;
	logic wait_oe_r;
	logic wait_oe_nxt;
	logic clear_r;
	logic clear_nxt;

	// Decode per personality; nothing is accepted before init ends
	always_comb
	begin
		attr_rd_nxt = 1'b0;
		attr_wr_nxt = 1'b0;
		tf_rd_nxt   = 1'b0;
		tf_wr_nxt   = 1'b0;
		dma_ack_nxt = 1'b0;
		dmarq_nxt   = 1'b0;
		pin37_nxt   = ready;
		pin24_nxt   = 1'b0;
		wait_o_nxt  = 1'b1;
		wait_oe_nxt = 1'b1;
		clear_nxt   = (state_r == card_port_pkg::st_hold) || (state_r == card_port_pkg::st_strap);
		case (mode)
			card_port_pkg::mode_mem:
			begin
				// REG high picks task file, low picks attribute space
				attr_rd_nxt = ready & ce_any & oe_fall & ~pin_s2_r[`PIN_REG];
				tf_rd_nxt   = ready & ce_any & oe_fall & pin_s2_r[`PIN_REG];
				attr_wr_nxt = ready & ce_any & we_fall & ~pin_s2_r[`PIN_REG];
				tf_wr_nxt   = ready & ce_any & we_fall & pin_s2_r[`PIN_REG];
			end
			card_port_pkg::mode_io:
			begin
				// OE and WE reach attribute space only; task file via I/O strobes
				attr_rd_nxt = ready & ce_any & oe_fall & ~pin_s2_r[`PIN_REG];
				attr_wr_nxt = ready & ce_any & we_fall & ~pin_s2_r[`PIN_REG];
				tf_rd_nxt   = ready & ce_any & iord_fall;
				tf_wr_nxt   = ready & ce_any & iowr_fall;
				pin37_nxt   = ~(ready & irq_req);
				pin24_nxt   = ~(ready & ce_word & ~(pin_s2_r[`PIN_IORD] & pin_s2_r[`PIN_IOWR]));
			end
			default:
			begin
				// IDE: WE ignored, writes wait for set up, ready pin floats
				tf_rd_nxt   = ready & ce_any & iord_fall;
				tf_wr_nxt   = ready & ce_any & iowr_fall;
				dmarq_nxt   = ready & dma_req;
				dma_ack_nxt = dmarq_r & ~pin_s2_r[`PIN_DMACK];
				pin37_nxt   = ready & irq_req;
				pin24_nxt   = ~(ready & word_xfer);
				wait_o_nxt  = 1'b0;
				wait_oe_nxt = 1'b0;
			end
		endcase
	end

	// Register decode results and pin levels
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			attr_rd_r <= 1'b0;
			attr_wr_r <= 1'b0;
			tf_rd_r   <= 1'b0;
			tf_wr_r   <= 1'b0;
			dma_ack_r <= 1'b0;
			dmarq_r   <= 1'b0;
			pin37_r   <= 1'b0;
			pin24_r   <= 1'b0;
			wait_o_r  <= 1'b1;
			wait_oe_r <= 1'b1;
			clear_r   <= 1'b1;
		end
		else
		begin
			attr_rd_r <= attr_rd_nxt;
			attr_wr_r <= attr_wr_nxt;
			tf_rd_r   <= tf_rd_nxt;
			tf_wr_r   <= tf_wr_nxt;
			dma_ack_r <= dma_ack_nxt;
			dmarq_r   <= dmarq_nxt;
			pin37_r   <= pin37_nxt;
			pin24_r   <= pin24_nxt;
			wait_o_r  <= wait_o_nxt;
			wait_oe_r <= wait_oe_nxt;
			clear_r   <= clear_nxt;
		end
	end

	// Output wiring
	assign attr_rd    = attr_rd_r;
	assign attr_wr    = attr_wr_r;
	assign tf_rd      = tf_rd_r;
	assign tf_wr      = tf_wr_r;
	assign dma_ack    = dma_ack_r;
	assign dmarq      = dmarq_r;
	assign rdy_irq_o  = pin37_r;
	assign wp_io16_o  = pin24_r;
	assign wait_o     = wait_o_r;
	assign wait_oe    = wait_oe_r;
	assign regs_clear = clear_r;
	assign busy       = ~ready;
	assign ide_mode   = strap_ide_r;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ide_irq;
		ready && (mode == card_port_pkg::mode_ide) && irq_req;
	endsequence

	sequence s_io_irq;
		ready && (mode == card_port_pkg::mode_io) && irq_req;
	endsequence

	sequence s_mem_tf_read;
		ready && (mode == card_port_pkg::mode_mem) && ce_any && oe_fall && pin_s2_r[`PIN_REG];
	endsequence

	a_wait_high: assert property ((mode != card_port_pkg::mode_ide) |=> (wait_o && wait_oe) || $changed(strap_ide_r))
		else $error("wait output not high in pc card mode");
	a_iordy_float: assert property ((mode == card_port_pkg::mode_ide) && $past(strap_ide_r) |-> !wait_oe)
		else $error("ready pin driven in ide mode");
	a_ide_irq_high: assert property (s_ide_irq |=> rdy_irq_o)
		else $error("ide interrupt not raised");
	a_io_irq_low: assert property (s_io_irq |=> !rdy_irq_o || (mode != card_port_pkg::mode_io))
		else $error("io interrupt not driven low");
	a_irq_quiet: assert property (!ready && $past(!ready) && (mode == card_port_pkg::mode_ide) |-> !rdy_irq_o)
		else $error("interrupt during initialization");
	a_busy_low: assert property (!ready && $past(!ready) && (mode == card_port_pkg::mode_mem) |-> !rdy_irq_o)
		else $error("ready shown during initialization");
	a_init_length: assert property ($rose(ready) |-> $past(cnt_r) == 16'(INIT_CYCLES - 1))
		else $error("initialization length wrong");
	a_iowr_gated: assert property (!ready |=> !tf_wr && !attr_wr)
		else $error("write accepted before set up");
	a_mem_reg_sel: assert property (s_mem_tf_read |=> tf_rd && !attr_rd)
		else $error("task file read not decoded");
	a_mode_hold: assert property (ready |=> $stable(strap_ide_r))
		else $error("mode strap changed while running");

endmodule

/* File: verification/host_bus_model.sv */
// Host bus controller model driving the card control pins as one vector.
// Assumes the bench calls set_pins from its main sequence only.
`timescale 1ns/1ps
`include "card_port_params.svh"
module host_bus_model (
	input  wire logic       clk,
	input  wire logic       dmarq,
	output logic [8:0]      pins
);
	// ****
	// Pin drive
	// ****
	logic [8:0] pin_r = `PIN_IDLE;
	logic       ack_r = 1'b0;
	// Acknowledge answers a pending DMA request
	always @(posedge clk)
		ack_r <= dmarq;
	// DMA acknowledge pulled low while a request stands
	assign pins = pin_r & ~({8'h00, ack_r} << `PIN_DMACK);
	// Apply a pin vector just after the next edge
	task automatic set_pins(input logic [8:0] v);
		@(posedge clk);
		pin_r <= v;
	endtask
endmodule

/* File: verification/tb_card_host_port_control_pins.sv */
// Self-checking bench for the card host port control pins.
// Assumes the host model drives all pins; short init count.
`timescale 1ns/1ps
`include "card_port_params.svh"
module tb_card_host_port_control_pins;
	// ****
	// Signals and instances
	// ****
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       io_mode_sel = 1'b0;
	logic       irq_req = 1'b0;
	logic       dma_req = 1'b0;
	logic       word_xfer = 1'b0;
	logic [8:0] pins;
	logic [8:0] idle_v;
	logic       pin24;
	logic       attr_rd, attr_wr, tf_rd, tf_wr, dma_ack, busy, regs_clear, ide_mode;
	logic       rdy_irq_o, wp_io16_o, wait_o, wait_oe, dmarq;
	int         error_cnt = 0;
	int         compares = 0;
	card_host_port #(.INIT_CYCLES(40)) u_dut (
		.clk(clk), .rst(rst), .oe_n(pins[`PIN_OE]), .we_n(pins[`PIN_WE]),
		.iord_n(pins[`PIN_IORD]), .iowr_n(pins[`PIN_IOWR]), .reg_n(pins[`PIN_REG]),
		.reset_pin(pins[`PIN_RESET]), .dmack_n(pins[`PIN_DMACK]), .ce1_n(pins[`PIN_CE1]),
		.ce2_n(pins[`PIN_CE2]), .io_mode_sel(io_mode_sel), .irq_req(irq_req), .dma_req(dma_req),
		.word_xfer(word_xfer), .attr_rd(attr_rd), .attr_wr(attr_wr), .tf_rd(tf_rd), .tf_wr(tf_wr),
		.dma_ack(dma_ack), .busy(busy), .regs_clear(regs_clear), .ide_mode(ide_mode),
		.rdy_irq_o(rdy_irq_o), .wp_io16_o(wp_io16_o), .wait_o(wait_o), .wait_oe(wait_oe), .dmarq(dmarq)
	);
	host_bus_model u_host (.clk(clk), .dmarq(dmarq), .pins(pins));
	// Clock of 5 ns
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	// ****
	// Helpers
	// ****
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Reset into a mode with the strap pins held through release
	task automatic start(input logic [8:0] v, input logic io);
		idle_v = v;
		u_host.set_pins(v);
		io_mode_sel <= io;
		rst <= 1'b1;
		cycles(20);
		rst <= 1'b0;
	endtask
	// Bounded wait for the end of initialization
	task automatic wait_ready();
		int n = 0;
		while (busy !== 1'b0)
		begin
			@(negedge clk);
			n++;
			if (n > 300)
			begin
				check("ready wait", 4'h1, 4'h0);
				end_of_test();
			end
		end
		cycles(2);
	endtask
	// One strobe with both enables low; collects the core pulses
	task automatic access(input string what, input int k, input logic r, input logic [3:0] exp);
		logic [8:0] v;
		logic [3:0] acc;
		v = idle_v & 9'h07F;
		v[`PIN_REG] = r;
		acc = 4'h0;
		u_host.set_pins(v);
		v[k] = 1'b0;
		u_host.set_pins(v);
		repeat (8)
		begin
			@(negedge clk);
			acc = acc | {attr_rd, attr_wr, tf_rd, tf_wr};
		end
		pin24 = wp_io16_o;
		v[k] = 1'b1;
		u_host.set_pins(v);
		u_host.set_pins(idle_v);
		cycles(2);
		check(what, acc, exp);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic test_mem();
		start(`PIN_IDLE, 1'b0);
		cycles(6);
		@(negedge clk);
		check("mem init", {2'h0, busy, rdy_irq_o}, 4'h2);
		wait_ready();
		@(negedge clk);
		check("mem ready", {ide_mode, rdy_irq_o, wait_o, wait_oe}, 4'h7);
		access("mem oe tf", `PIN_OE, 1'b1, 4'h2);
		access("mem oe attr", `PIN_OE, 1'b0, 4'h8);
		access("mem we tf", `PIN_WE, 1'b1, 4'h1);
		access("mem we attr", `PIN_WE, 1'b0, 4'h4);
		check("mem wp", {3'h0, pin24}, 4'h0);
		u_host.set_pins(idle_v | 9'h020);
		cycles(4);
		@(negedge clk);
		check("mem pin reset", {2'h0, busy, rdy_irq_o}, 4'h2);
		u_host.set_pins(idle_v);
		wait_ready();
		$display("test mem finished");
	endtask
	task automatic test_io();
		start(`PIN_IDLE, 1'b1);
		wait_ready();
		@(negedge clk);
		check("io irq idle", {1'b0, wp_io16_o, rdy_irq_o, wait_oe}, 4'h7);
		cycles(1);
		irq_req <= 1'b1;
		cycles(3);
		@(negedge clk);
		check("io irq on", {2'h0, rdy_irq_o, wait_o}, 4'h1);
		access("io oe attr", `PIN_OE, 1'b0, 4'h8);
		access("io oe reg high", `PIN_OE, 1'b1, 4'h0);
		access("io we attr", `PIN_WE, 1'b0, 4'h4);
		access("io rd tf", `PIN_IORD, 1'b0, 4'h2);
		check("io wide", {3'h0, pin24}, 4'h0);
		access("io wr tf", `PIN_IOWR, 1'b0, 4'h1);
		u_host.set_pins(idle_v | 9'h020);
		cycles(4);
		@(negedge clk);
		check("io pin reset", {2'h0, busy, rdy_irq_o}, 4'h3);
		u_host.set_pins(idle_v);
		irq_req <= 1'b0;
		wait_ready();
		$display("test io finished");
	endtask
	task automatic test_ide();
		start(9'h1FE, 1'b0);
		access("ide early wr", `PIN_IOWR, 1'b0, 4'h0);
		wait_ready();
		@(negedge clk);
		check("ide mode", {1'b0, regs_clear, ide_mode, wait_oe}, 4'h2);
		access("ide rd", `PIN_IORD, 1'b0, 4'h2);
		access("ide wr", `PIN_IOWR, 1'b0, 4'h1);
		irq_req <= 1'b1;
		word_xfer <= 1'b1;
		dma_req <= 1'b1;
		cycles(2);
		@(negedge clk);
		check("ide irq word dma", {1'b0, rdy_irq_o, wp_io16_o, dmarq}, 4'h5);
		cycles(6);
		@(negedge clk);
		check("ide dma ack", {3'h0, dma_ack}, 4'h1);
		cycles(1);
		word_xfer <= 1'b0;
		dma_req <= 1'b0;
		cycles(3);
		@(negedge clk);
		check("ide byte", {1'b0, dma_ack, wp_io16_o, dmarq}, 4'h2);
		u_host.set_pins(idle_v & 9'h1DF);
		cycles(4);
		@(negedge clk);
		check("ide pin reset", {2'h0, regs_clear, rdy_irq_o}, 4'h2);
		u_host.set_pins(idle_v);
		irq_req <= 1'b0;
		wait_ready();
		check("ide kept", {3'h0, ide_mode}, 4'h1);
		$display("test ide finished");
	endtask
	// Main sequence
	initial
	begin
		test_mem();
		test_io();
		test_ide();
		end_of_test();
	end
endmodule
